// ### rtl/dcid_consts.svh
`ifndef DCID_CONSTS_SVH
`define DCID_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DCID_OFS_CTRL    12'h000
`define DCID_OFS_STATUS  12'h004
`define DCID_OFS_LAST    12'h008
`define DCID_OFS_CYCLES  12'h00c
`define DCID_OFS_TRAPS   12'h010
`define DCID_CTRL_RST    2'h1
`define DCID_CTRL_EN     0
`define DCID_CTRL_TRAPEN 1
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define DCID_OP_NOP      8'h00
`define DCID_OP_BRANCH   8'h01
`define DCID_OP_BRACOND  8'h02
`define DCID_OP_CALLI    8'h03
`define DCID_OP_GOTOI    8'h04
`define DCID_OP_TBLRD    8'h05
`define DCID_OP_TBLWR    8'h06
`define DCID_OP_RET      8'h07
`define DCID_OP_RETINT   8'h08
`define DCID_OP_SKIP     8'h09
`define DCID_OP_MOVD     8'h0a
`define DCID_OP_GOTO     8'h0b
`define DCID_OP_CALL     8'h0c
`define DCID_OP_DO       8'h0d
`define DCID_OP_ALU3     6'h04
`define DCID_OP_FILE     6'h05
`define DCID_OP_LIT      6'h06
`define DCID_OP_BIT      8'h1c
`define DCID_OP_MAC      8'h20
`define DCID_OP_SHIFT    8'h21
// ----------------------------------------
// Cycle counts and limits
// ----------------------------------------
`define DCID_CYC_ONE     2'h1
`define DCID_CYC_TWO     2'h2
`define DCID_CYC_THREE   2'h3
`define DCID_BYTE_LIMIT  10'h0ff
`define DCID_MUL_PAIRS   3'h6
`define DCID_REG_WB_DEST 4'hd
`define DCID_REG_MULBASE 4'h4
`endif

// ### rtl/dcid_pkg.sv
package dcid_pkg;
   typedef enum logic [3:0] {
      DCID_ILLEGAL, DCID_NOP, DCID_CTRL, DCID_SKIP, DCID_MOVD, DCID_TWO,
      DCID_ALU3, DCID_FILE, DCID_LIT, DCID_BIT, DCID_MAC, DCID_SHIFT
   } dcid_class_e;
   typedef enum logic [1:0] {
      DCID_W_WORD = 2'h0, DCID_W_BYTE = 2'h1, DCID_W_DWORD = 2'h2
   } dcid_width_e;
   typedef enum logic [3:0] {
      DCID_S_FETCH = 4'h1, DCID_S_WORD2 = 4'h2, DCID_S_EXTRA = 4'h4, DCID_S_DROP2 = 4'h8
   } dcid_state_e;
   typedef struct packed {
      logic c; logic digit_carry_flag; logic n; logic overflow_flag; logic z;
   } dcid_mcu_flags_s;
   typedef struct packed {
      logic acc_a_overflow_flag; logic acc_b_overflow_flag; logic acc_a_saturate_flag; logic acc_b_saturate_flag;
   } dcid_acc_flags_s;
   typedef struct packed {
      dcid_class_e     cls;
      logic [7:0]      opcode;
      dcid_width_e     width;
      logic [3:0]      base_src_reg;
      logic [3:0]      second_src_reg;
      logic [1:0]      src_mode;
      logic [3:0]      dest_reg;
      logic [1:0]      dest_mode;
      logic [12:0]     file_addr;
      logic            to_default_work_reg;
      logic [9:0]      ten_bit_literal;
      logic [3:0]      bit_select_field;
      logic            bit_indirect;
      logic [22:0]     program_address_literal;
      logic            acc_b;
      logic [3:0]      mul_a;
      logic [3:0]      mul_b;
      logic [2:0]      x_prefetch;
      logic [2:0]      y_prefetch;
      logic [3:0]      x_dest;
      logic [3:0]      y_dest;
      logic [1:0]      acc_writeback_target;
      logic            shift_literal;
      logic [3:0]      shift_amount;
      logic [1:0]      cycles;
      dcid_mcu_flags_s flag_mask;
   } dcid_dec_s;
endpackage : dcid_pkg

// ### rtl/dcid_decoder.sv
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "dcid_consts.svh"
module dcid_decoder
   import dcid_pkg::*;
(
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire logic [31:0]     pwdata,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   input  wire logic            instr_valid,
   input  wire logic [23:0]     instr_word,
   output logic                 instr_ready,
   output logic                 dec_valid,
   output dcid_dec_s            dec,
   output logic                 nop_cycle,
   output logic                 trap,
   input  wire logic            alu_done,
   input  wire dcid_mcu_flags_s alu_flags,
   input  wire logic            acc_done,
   input  wire dcid_acc_flags_s acc_flags,
   output dcid_mcu_flags_s      mcu_flags,
   output dcid_acc_flags_s      acc_status
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic is_two_word(input logic [7:0] op);
      return op == `DCID_OP_GOTO || op == `DCID_OP_CALL || op == `DCID_OP_DO;
   endfunction : is_two_word

   function automatic logic cond_true(input logic [3:0] sel, input dcid_mcu_flags_s f);
      logic v;
      v = 1'b0;
      unique case (sel[2:0])
         3'h0: v = f.c;
         3'h1: v = f.digit_carry_flag;
         3'h2: v = f.n;
         3'h3: v = f.overflow_flag;
         3'h4: v = f.z;
         default: v = 1'b1;
      endcase
      return v ^ sel[3];
   endfunction : cond_true

   // ----------------------------------------
   // Decode of one word
   // ----------------------------------------
   function automatic dcid_dec_s decode(input logic [23:0] w, input dcid_mcu_flags_s f);
      dcid_dec_s d;
      logic [7:0] op;
      d = '0;
      op = w[23:16];
      d.opcode = op;
      d.cls = DCID_ILLEGAL;
      d.cycles = `DCID_CYC_ONE;
      d.width = (op[1:0] == 2'h3) ? DCID_W_WORD : dcid_width_e'(op[1:0]);
      d.base_src_reg = w[15:12];
      d.second_src_reg = w[11:8];
      d.src_mode = w[7:6];
      d.dest_mode = w[5:4];
      d.dest_reg = w[3:0];
      if (op == `DCID_OP_NOP) begin
         d.cls = DCID_NOP;
      end else if (op == `DCID_OP_BRANCH || op == `DCID_OP_CALLI || op == `DCID_OP_GOTOI ||
                   op == `DCID_OP_TBLRD || op == `DCID_OP_TBLWR) begin
         d.cls = DCID_CTRL;
         d.cycles = `DCID_CYC_TWO;
      end else if (op == `DCID_OP_RET || op == `DCID_OP_RETINT) begin
         d.cls = DCID_CTRL;
         d.cycles = `DCID_CYC_THREE;
      end else if (op == `DCID_OP_BRACOND) begin
         d.cls = DCID_CTRL;
         d.cycles = cond_true(w[3:0], f) ? `DCID_CYC_TWO : `DCID_CYC_ONE;
      end else if (op == `DCID_OP_SKIP) begin
         d.cls = DCID_SKIP;
      end else if (op == `DCID_OP_MOVD) begin
         d.cls = DCID_MOVD;
         d.width = DCID_W_DWORD;
         d.cycles = `DCID_CYC_TWO;
      end else if (is_two_word(op)) begin
         d.cls = DCID_TWO;
         d.cycles = `DCID_CYC_TWO;
         d.program_address_literal[22:16] = w[6:0];
      end else if (op[7:2] == `DCID_OP_ALU3) begin
         d.cls = DCID_ALU3;
         d.flag_mask = '1;
      end else if (op[7:2] == `DCID_OP_FILE) begin
         d.cls = DCID_FILE;
         d.file_addr = w[12:0];
         d.to_default_work_reg = w[13];
         d.flag_mask = '1;
      end else if (op[7:2] == `DCID_OP_LIT) begin
         d.cls = DCID_LIT;
         d.ten_bit_literal = w[13:4];
         d.flag_mask = '{c: 1'b0, digit_carry_flag: 1'b0, n: 1'b1, overflow_flag: 1'b0, z: 1'b1};
         if (d.width == DCID_W_BYTE && w[13:4] > `DCID_BYTE_LIMIT) begin
            d.cls = DCID_ILLEGAL;
         end
      end else if (op == `DCID_OP_BIT) begin
         d.cls = DCID_BIT;
         d.bit_select_field = w[15:12];
         d.bit_indirect = w[11];
         d.flag_mask.z = 1'b1;
      end else if (op == `DCID_OP_MAC) begin
         d.cls = DCID_MAC;
         d.acc_b = w[15];
         unique case (w[14:12])
            3'h0: {d.mul_a, d.mul_b} = {4'h4, 4'h5};
            3'h1: {d.mul_a, d.mul_b} = {4'h4, 4'h6};
            3'h2: {d.mul_a, d.mul_b} = {4'h4, 4'h7};
            3'h3: {d.mul_a, d.mul_b} = {4'h5, 4'h6};
            3'h4: {d.mul_a, d.mul_b} = {4'h5, 4'h7};
            3'h5: {d.mul_a, d.mul_b} = {4'h6, 4'h7};
            default: {d.mul_a, d.mul_b} = 8'h00;
         endcase
         d.x_prefetch = w[11:9];
         d.y_prefetch = w[8:6];
         d.x_dest = `DCID_REG_MULBASE + {2'h0, w[5:4]};
         d.y_dest = `DCID_REG_MULBASE + {2'h0, w[3:2]};
         d.acc_writeback_target = w[1:0];
         if (w[14:12] >= `DCID_MUL_PAIRS || w[1:0] == 2'h3) begin
            d.cls = DCID_ILLEGAL;
         end
      end else if (op == `DCID_OP_SHIFT) begin
         d.cls = DCID_SHIFT;
         d.acc_b = w[14];
         d.shift_literal = w[15];
         d.shift_amount = w[3:0];
      end
      return d;
   endfunction : decode

   // ----------------------------------------
   // APB registers
   // ----------------------------------------
   logic [1:0]  ctrl_q;
   logic [23:0] last_q;
   logic [1:0]  cyc_q;
   logic [15:0] traps_q;
   logic        acc_phase;
   logic        hit;
   logic [31:0] rd_d;

   assign acc_phase = psel && penable && !pready;

   always_comb begin
      hit = 1'b1;
      rd_d = 32'h0;
      unique case (paddr)
         `DCID_OFS_CTRL:   rd_d = {30'h0, ctrl_q};
         `DCID_OFS_STATUS: rd_d = {23'h0, acc_status, mcu_flags};
         `DCID_OFS_LAST:   rd_d = {8'h0, last_q};
         `DCID_OFS_CYCLES: rd_d = {30'h0, cyc_q};
         `DCID_OFS_TRAPS:  rd_d = {16'h0, traps_q};
         default:          hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= acc_phase;
         pslverr <= acc_phase && !hit;
         prdata <= (acc_phase && !pwrite) ? rd_d : 32'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `DCID_CTRL_RST;
      end else if (psel && penable && pready && pwrite && paddr == `DCID_OFS_CTRL) begin
         ctrl_q <= pwdata[1:0];
      end
   end

   // ----------------------------------------
   // Fetch sequencer
   // ----------------------------------------
   dcid_state_e state_q;
   dcid_state_e state_d;
   dcid_dec_s   cur;
   dcid_dec_s   pair;
   logic [23:0] first_q;
   logic [1:0]  extra_q;
   logic        skip_q;
   logic        take;
   logic        bad2;

   assign take = instr_valid && instr_ready;
   assign cur = decode(instr_word, mcu_flags);

   always_comb begin
      pair = decode(first_q, mcu_flags);
      pair.program_address_literal[15:0] = instr_word[15:0];
      bad2 = instr_word[23:16] != 8'h00;
      if (first_q[23:16] != `DCID_OP_DO && instr_word[0]) begin
         bad2 = 1'b1;
      end
   end

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         DCID_S_FETCH: begin
            if (take && skip_q) begin
               state_d = is_two_word(cur.opcode) ? DCID_S_DROP2 : DCID_S_FETCH;
            end else if (take && cur.cls == DCID_TWO) begin
               state_d = DCID_S_WORD2;
            end else if (take && cur.cls != DCID_ILLEGAL && cur.cycles != `DCID_CYC_ONE) begin
               state_d = DCID_S_EXTRA;
            end
         end
         DCID_S_WORD2: if (take) state_d = DCID_S_FETCH;
         DCID_S_DROP2: if (take) state_d = DCID_S_FETCH;
         DCID_S_EXTRA: if (extra_q == 2'h1) state_d = DCID_S_FETCH;
         default:      state_d = DCID_S_FETCH;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= DCID_S_FETCH;
         instr_ready <= 1'b0;
      end else begin
         state_q <= state_d;
         instr_ready <= ctrl_q[`DCID_CTRL_EN] && state_d != DCID_S_EXTRA;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         extra_q <= 2'h0;
      end else if (state_q == DCID_S_EXTRA) begin
         extra_q <= extra_q - 2'h1;
      end else if (take && state_q == DCID_S_FETCH && !skip_q) begin
         extra_q <= cur.cycles - 2'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         skip_q <= 1'b0;
      end else if (take && state_q == DCID_S_FETCH) begin
         skip_q <= !skip_q && cur.cls == DCID_SKIP && cond_true(instr_word[3:0], mcu_flags);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_q <= 24'h0;
      end else if (take && state_q == DCID_S_FETCH) begin
         first_q <= instr_word;
      end
   end

   // ----------------------------------------
   // Issue to execute
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_valid <= 1'b0;
         dec <= '0;
         nop_cycle <= 1'b0;
         trap <= 1'b0;
      end else begin
         dec_valid <= 1'b0;
         nop_cycle <= state_q == DCID_S_EXTRA;
         trap <= 1'b0;
         if (take && state_q == DCID_S_FETCH) begin
            if (skip_q) begin
               nop_cycle <= 1'b1;
            end else if (cur.cls == DCID_ILLEGAL) begin
               trap <= ctrl_q[`DCID_CTRL_TRAPEN];
            end else if (cur.cls != DCID_TWO) begin
               dec_valid <= 1'b1;
               dec <= cur;
            end
         end else if (take && state_q == DCID_S_DROP2) begin
            nop_cycle <= 1'b1;
         end else if (take && state_q == DCID_S_WORD2) begin
            if (bad2) begin
               trap <= ctrl_q[`DCID_CTRL_TRAPEN];
            end else begin
               dec_valid <= 1'b1;
               dec <= pair;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_q <= 24'h0;
         cyc_q <= 2'h0;
      end else if (take && (state_q == DCID_S_FETCH || state_q == DCID_S_WORD2)) begin
         last_q <= instr_word;
         cyc_q <= (state_q == DCID_S_WORD2) ? `DCID_CYC_TWO : cur.cycles;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         traps_q <= 16'h0;
      end else if (take && ((state_q == DCID_S_FETCH && !skip_q && cur.cls == DCID_ILLEGAL) ||
                            (state_q == DCID_S_WORD2 && bad2))) begin
         traps_q <= traps_q + 16'h1;
      end
   end

   // ----------------------------------------
   // Status flags
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mcu_flags <= '0;
      end else if (alu_done) begin
         mcu_flags <= (mcu_flags & ~dec.flag_mask) | (alu_flags & dec.flag_mask);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_status <= '0;
      end else if (acc_done) begin
         acc_status <= acc_flags;
      end
   end
endmodule : dcid_decoder

// ### tb/dcid_asserts.sv
`timescale 1ns/1ps
module dcid_asserts
   import dcid_pkg::*;
(
   input wire logic            pclk,
   input wire logic            presetn,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [11:0]     paddr,
   input wire logic [31:0]     pwdata,
   input wire logic [31:0]     prdata,
   input wire logic            pready,
   input wire logic            pslverr,
   input wire logic            instr_valid,
   input wire logic [23:0]     instr_word,
   input wire logic            instr_ready,
   input wire logic            dec_valid,
   input wire dcid_dec_s       dec,
   input wire logic            nop_cycle,
   input wire logic            trap,
   input wire logic            alu_done,
   input wire dcid_mcu_flags_s alu_flags,
   input wire logic            acc_done,
   input wire dcid_acc_flags_s acc_flags,
   input wire dcid_mcu_flags_s mcu_flags,
   input wire dcid_acc_flags_s acc_status
);
   default clocking dcb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_apb_answer: assert property (psel && penable && !pready |=> pready) else $error("pready late");
   chk_apb_pulse: assert property (pready |=> !pready) else $error("pready held");
   chk_opcode_take: assert property (
      dec_valid && !(dec.cls inside {DCID_TWO, DCID_ILLEGAL}) |->
      $past(instr_valid && instr_ready) && dec.opcode == $past(instr_word[23:16])) else $error("opcode");
   chk_pair_second: assert property (
      dec_valid && dec.cls == DCID_TWO |-> dec.opcode inside {8'h0b, 8'h0c, 8'h0d} &&
      $past(instr_word[23:16]) == 8'h00 && dec.program_address_literal[15:0] == $past(instr_word[15:0]))
      else $error("pair word");
   chk_addr_lsb: assert property (dec_valid && dec.cls == DCID_TWO && dec.opcode != 8'h0d |->
      !dec.program_address_literal[0]) else $error("address lsb");
   chk_two_cycle: assert property (dec_valid && dec.cls inside {DCID_TWO, DCID_MOVD} |->
      dec.cycles == 2'h2) else $error("two cycles");
   chk_one_cycle: assert property (dec_valid &&
      dec.cls inside {DCID_NOP, DCID_ALU3, DCID_FILE, DCID_LIT, DCID_BIT, DCID_MAC, DCID_SHIFT} |->
      dec.cycles == 2'h1 ##1 !nop_cycle) else $error("one cycle");
   chk_ctrl_cycles: assert property (dec_valid && dec.cls == DCID_CTRL &&
      dec.opcode inside {8'h01, 8'h03, 8'h04, 8'h05, 8'h06} |-> dec.cycles == 2'h2) else $error("ctrl");
   chk_ret_cycles: assert property (dec_valid && dec.cls == DCID_CTRL && dec.opcode inside {8'h07, 8'h08} |->
      dec.cycles == 2'h3 ##1 nop_cycle ##1 nop_cycle) else $error("return");
   chk_added_nop: assert property (dec_valid && dec.cls == DCID_CTRL && dec.cycles == 2'h2 |->
      !instr_ready ##1 nop_cycle) else $error("added nop");
   chk_width_code: assert property (dec_valid && dec.cls inside {DCID_ALU3, DCID_FILE, DCID_LIT} |->
      dec.width == (dec.opcode[1:0] == 2'h1 ? DCID_W_BYTE : dec.opcode[1:0] == 2'h2 ? DCID_W_DWORD : DCID_W_WORD))
      else $error("width");
   chk_mul_pair: assert property (dec_valid && dec.cls == DCID_MAC |-> dec.mul_a >= 4'h4 &&
      dec.mul_b <= 4'h7 && dec.mul_a < dec.mul_b) else $error("multiply pair");
   chk_flag_merge: assert property (alu_done |=> mcu_flags ==
      (($past(alu_flags) & $past(dec.flag_mask)) | ($past(mcu_flags) & ~$past(dec.flag_mask))))
      else $error("mcu flags");
   chk_acc_load: assert property (acc_done |=> acc_status == $past(acc_flags)) else $error("acc flags");
   chk_trap_take: assert property (trap |-> $past(instr_valid && instr_ready)) else $error("trap");
endmodule : dcid_asserts

// ### tb/dcid_progmem.sv
`timescale 1ns/1ps
module dcid_progmem (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        instr_ready,
   output logic             instr_valid,
   output logic [23:0]      instr_word
);
   logic [23:0] q[$];
   int          seed = 72404;
   // ----------------------------------------
   // Offer words in order, hold each until taken
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_valid <= 1'b0;
         instr_word  <= 24'h000000;
      end else if (!instr_valid || instr_ready) begin
         if (instr_valid) void'(q.pop_front());
         if (q.size() > 0 && ($random(seed) & 3) != 0) begin
            instr_valid <= 1'b1;
            instr_word  <= q[0];
         end else begin
            instr_valid <= 1'b0;
            instr_word  <= ~instr_word;
         end
      end
   end
endmodule : dcid_progmem

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "dcid_consts.svh"
module testbench
   import dcid_pkg::*;
;
   logic            pclk, presetn, psel, penable, pwrite, alu_done, acc_done;
   logic [11:0]     paddr;
   logic [31:0]     pwdata, prdata;
   logic            pready, pslverr, instr_valid, instr_ready, dec_valid, nop_cycle, trap;
   logic [23:0]     instr_word;
   dcid_dec_s       dec;
   dcid_mcu_flags_s alu_flags, mcu_flags;
   dcid_acc_flags_s acc_flags, acc_status;
   int              err_total, comparisons, nops, traps, n_nop;
   int              seed = 72404;
   int              e_op[$], e_cyc[$];
   logic [22:0]     e_pa[$];
   dcid_decoder dcid_decoder_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .instr_valid, .instr_word, .instr_ready, .dec_valid, .dec, .nop_cycle, .trap, .alu_done,
      .alu_flags, .acc_done, .acc_flags, .mcu_flags, .acc_status);
   dcid_progmem mem_i (.pclk, .presetn, .instr_ready, .instr_valid, .instr_word);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task summarize;
      if (err_total == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task rd(input logic [11:0] a, input logic [31:0] x, input logic ex);
      logic [31:0] g;
      logic        e;
      apb(1'b0, a, 32'h0, g, e);
      chk("prdata", x, g);
      chk("pslverr", ex, e);
   endtask : rd
   task wr(input logic [11:0] a, input logic [31:0] d, input logic ex);
      logic [31:0] g;
      logic        e;
      apb(1'b1, a, d, g, e);
      chk("pslverr", ex, e);
   endtask : wr
   task ins(input logic [23:0] w, input int c, input logic [22:0] pa);
      mem_i.q.push_back(w);
      e_op.push_back(w[23:16]); e_cyc.push_back(c); e_pa.push_back(pa);
      if (c > 1 && !(w[23:16] inside {8'h0b, 8'h0c, 8'h0d})) n_nop += c - 1;
   endtask : ins
   task drain;
      int n;
      n = 0;
      while ((e_op.size() > 0 || mem_i.q.size() > 0) && n < 3000) begin @(posedge pclk); n++; end
      if (n >= 3000) chk("drain limit", 0, n);
      repeat (4) @(posedge pclk);
   endtask : drain
   function automatic logic [3:0] cls_of(input int op);
      case (op) inside
         0: return DCID_NOP;
         [1:8]: return DCID_CTRL;
         9: return DCID_SKIP;
         10: return DCID_MOVD;
         [11:13]: return DCID_TWO;
         [16:19]: return DCID_ALU3;
         [20:23]: return DCID_FILE;
         [24:27]: return DCID_LIT;
         28: return DCID_BIT;
         32: return DCID_MAC;
         33: return DCID_SHIFT;
         default: return DCID_ILLEGAL;
      endcase
   endfunction : cls_of
   // ----------------------------------------
   // Result monitor against the model
   // ----------------------------------------
   always @(posedge pclk) begin
      if (nop_cycle === 1'b1) nops++;
      if (trap === 1'b1) traps++;
      if (dec_valid === 1'b1 && dec.cls !== DCID_ILLEGAL) begin
         if (e_op.size() == 0) chk("unexpected issue", 0, 1);
         else begin
            chk("opcode", e_op[0], dec.opcode);
            chk("class", cls_of(e_op[0]), dec.cls);
            if (e_cyc[0] > 0) chk("cycles", e_cyc[0], dec.cycles);
            if (e_op[0] inside {[16:27]}) chk("width", e_op[0] % 4 == 1 ? DCID_W_BYTE :
               e_op[0] % 4 == 2 ? DCID_W_DWORD : DCID_W_WORD, dec.width);
            if (e_op[0] inside {[11:13]}) chk("address", e_pa[0], dec.program_address_literal);
            void'(e_op.pop_front()); void'(e_cyc.pop_front()); void'(e_pa.pop_front());
         end
      end
   end
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      repeat (30000) @(posedge pclk);
      err_total++;
      summarize();
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      int          s, v, t0;
      logic [15:0] r;
      logic [22:0] pa;
      logic [31:0] d;
      logic        e;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
      alu_done = 1'b0; alu_flags = 5'h00; acc_done = 1'b0; acc_flags = 4'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (s = 0; s < 5; s++) rd(12'(s * 4), (s == 0), 1'b0);
      rd(12'h020, 32'h0, 1'b1);
      wr(12'h020, 32'hffffffff, 1'b1);
      wr(`DCID_OFS_TRAPS, 32'h5, 1'b0);
      rd(`DCID_OFS_TRAPS, 32'h0, 1'b0);
      wr(`DCID_OFS_CTRL, 32'h3, 1'b0);
      rd(`DCID_OFS_CTRL, 32'h3, 1'b0);
      for (s = 0; s < 11; s++) if (s != 2 && s != 9) begin r = $random(seed); ins({s[7:0], r}, (s == 7 || s == 8) ? 3 : (s == 0) ? 1 : 2, 23'h0); end
      for (s = 0; s < 11; s++) begin
         r = $random(seed);
         v = (s == 10) ? 7 : (s / 5) * 8 + s % 5;
         ins({8'h02, r[15:4], v[3:0]}, s >= 5 ? 2 : 1, 23'h0);
         ins({8'h09, r[15:4], v[3:0]}, 0, 23'h0);
         pa = {r[6:0], r[15:1], 1'b0};
         if (s == 10) begin mem_i.q.push_back({8'h0b, 9'h0, pa[22:16]}); mem_i.q.push_back({8'h00, pa[15:0]}); n_nop += 2; end
         else if (s >= 5) begin mem_i.q.push_back({8'h01, r}); n_nop += 1; end
         else ins({8'h01, r}, 2, 23'h0);
      end
      for (s = 11; s < 14; s++) begin
         r = $random(seed);
         pa = {r[6:0], r[15:1], 1'b0};
         ins({s[7:0], r[15:7], pa[22:16]}, 2, pa);
         mem_i.q.push_back({8'h00, pa[15:0]});
      end
      for (s = 16; s < 34; s++) if (cls_of(s) !== DCID_ILLEGAL) begin r = $random(seed); ins({s[7:0], 8'h00, (s == 32) ? 8'h00 : r[7:0]}, 1, 23'h0); end
      drain();
      chk("nop count", n_nop, nops);
      wr(`DCID_OFS_CTRL, 32'h2, 1'b0);
      @(posedge pclk);
      ins(24'h000000, 1, 23'h0);
      repeat (8) @(posedge pclk);
      chk("pending", 1, e_op.size());
      chk("instr_ready", 0, instr_ready);
      wr(`DCID_OFS_CTRL, 32'h3, 1'b0);
      drain();
      t0 = traps;
      r = $random(seed);
      mem_i.q.push_back({8'hff, r});
      mem_i.q.push_back({8'h0e, r});
      ins({8'h01, r}, 2, 23'h0);
      drain();
      chk("trap count", t0 + 2, traps);
      rd(`DCID_OFS_TRAPS, 32'h2, 1'b0);
      rd(`DCID_OFS_LAST, {8'h00, 8'h01, r}, 1'b0);
      rd(`DCID_OFS_CYCLES, 32'h2, 1'b0);
      ins({8'h10, 16'h0000}, 1, 23'h0);
      drain();
      for (s = 0; s < 2; s++) begin
         r = $random(seed);
         @(posedge pclk);
         alu_flags <= r[4:0]; alu_done <= 1'b1; acc_flags <= s ? 4'h5 : 4'ha; acc_done <= 1'b1;
         @(posedge pclk);
         alu_done <= 1'b0; acc_done <= 1'b0;
         @(posedge pclk);
         chk("acc_status", s ? 4'h5 : 4'ha, acc_status);
         apb(1'b0, `DCID_OFS_STATUS, 32'h0, d, e);
         chk("status acc", s ? 4'h5 : 4'ha, d[8:5]);
         chk("status mcu", r[4:0], d[4:0]);
      end
      summarize();
   end
endmodule : testbench
bind dcid_decoder dcid_asserts dcid_asserts_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .instr_valid, .instr_word, .instr_ready, .dec_valid, .dec, .nop_cycle, .trap,
   .alu_done, .alu_flags, .acc_done, .acc_flags, .mcu_flags, .acc_status);
